// file: jtd_pkg.sv
package jtd_pkg;
  // instruction register
  localparam int IrWidth = 4;
  localparam logic [3:0] IrCaptureVal = 4'h1;
  // instruction codes; the core's debug set is routed to the core TAP
  localparam logic [3:0] InstrExtest = 4'h0;
  localparam logic [3:0] InstrIntest = 4'h1;
  localparam logic [3:0] InstrSamplePreload = 4'h2;
  localparam logic [3:0] InstrAbort = 4'h8;
  localparam logic [3:0] InstrDebugPortAccess = 4'ha;
  localparam logic [3:0] InstrAccessPortAccess = 4'hb;
  localparam logic [3:0] InstrIdcode = 4'he;
  localparam logic [3:0] InstrBypass = 4'hf;
  // identification word; value is arbitrary
  localparam logic [31:0] IdcodeVal = 32'h1234_5677;
  localparam int IdWidth = 32;
  localparam int BsWidth = 8;

  // tap states, one-hot
  typedef enum logic [15:0] {
    TestLogicReset = 16'h0001,
    RunTestIdle = 16'h0002,
    SelectDr = 16'h0004,
    CaptureDr = 16'h0008,
    ShiftDr = 16'h0010,
    Exit1Dr = 16'h0020,
    PauseDr = 16'h0040,
    Exit2Dr = 16'h0080,
    UpdateDr = 16'h0100,
    SelectIr = 16'h0200,
    CaptureIr = 16'h0400,
    ShiftIr = 16'h0800,
    Exit1Ir = 16'h1000,
    PauseIr = 16'h2000,
    Exit2Ir = 16'h4000,
    UpdateIr = 16'h8000
  } jtd_state_t;
endpackage : jtd_pkg

// file: jtd_tap.sv
`timescale 1ns/1ns
module jtd_tap #(
  parameter int BsLen = jtd_pkg::BsWidth
) (
  // system
  input wire logic clk,
  input wire logic arst_n,
  // jtag pins, asynchronous to clk
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic trstN,
  output logic tdoOut,
  output logic tdoOe,
  // core debug tap
  input wire logic coreTdo,
  // boundary cells
  input wire logic [BsLen-1:0] pinSample,
  output logic [BsLen-1:0] pinDrive,
  output logic testMode
);

  typedef struct packed {
    logic [1:0] tckSync;
    logic [1:0] tmsSync;
    logic [1:0] tdiSync;
    logic [1:0] trstSync;
    logic [1:0] coreSync;
    logic [1:0][BsLen-1:0] pinSync;
    logic tckLast;
    jtd_pkg::jtd_state_t state;
    logic [jtd_pkg::IrWidth-1:0] irShift;
    logic [jtd_pkg::IrWidth-1:0] irHold;
    logic [jtd_pkg::IdWidth-1:0] drShift;
    logic [BsLen-1:0] bsHold;
    logic tdo;
    logic oe;
    logic mode;
  } jtd_regs_t;

  jtd_regs_t r_reg;
  jtd_regs_t r_next;

  logic tckRise;
  logic tckFall;
  logic tmsS;
  logic tdiS;
  logic trstActive;
  logic coreSel;
  logic useBypass;
  logic useId;
  logic useBs;
  jtd_pkg::jtd_state_t nextState;

  // edge detect reads only the second sync stage
  assign tckRise = r_reg.tckSync[1] & ~r_reg.tckLast;
  assign tckFall = ~r_reg.tckSync[1] & r_reg.tckLast;
  assign tmsS = r_reg.tmsSync[1];
  assign tdiS = r_reg.tdiSync[1];
  assign trstActive = ~r_reg.trstSync[1];

  // instruction decode; anything unknown falls back to bypass
  always_comb begin
    coreSel = 1'b0;
    useBypass = 1'b0;
    useId = 1'b0;
    useBs = 1'b0;
    case (r_reg.irHold)
      jtd_pkg::InstrAbort,
      jtd_pkg::InstrDebugPortAccess,
      jtd_pkg::InstrAccessPortAccess: coreSel = 1'b1;
      jtd_pkg::InstrIdcode: useId = 1'b1;
      jtd_pkg::InstrSamplePreload: useBs = 1'b1;
      jtd_pkg::InstrExtest,
      jtd_pkg::InstrIntest: useBypass = 1'b1;
      default: useBypass = 1'b1;
    endcase
  end

  // standard tap transition table
  always_comb begin
    nextState = r_reg.state;
    case (r_reg.state)
      jtd_pkg::TestLogicReset:
        nextState = tmsS ? jtd_pkg::TestLogicReset : jtd_pkg::RunTestIdle;
      jtd_pkg::RunTestIdle:
        nextState = tmsS ? jtd_pkg::SelectDr : jtd_pkg::RunTestIdle;
      jtd_pkg::SelectDr:
        nextState = tmsS ? jtd_pkg::SelectIr : jtd_pkg::CaptureDr;
      jtd_pkg::CaptureDr:
        nextState = tmsS ? jtd_pkg::Exit1Dr : jtd_pkg::ShiftDr;
      jtd_pkg::ShiftDr:
        nextState = tmsS ? jtd_pkg::Exit1Dr : jtd_pkg::ShiftDr;
      jtd_pkg::Exit1Dr:
        nextState = tmsS ? jtd_pkg::UpdateDr : jtd_pkg::PauseDr;
      jtd_pkg::PauseDr:
        nextState = tmsS ? jtd_pkg::Exit2Dr : jtd_pkg::PauseDr;
      jtd_pkg::Exit2Dr:
        nextState = tmsS ? jtd_pkg::UpdateDr : jtd_pkg::ShiftDr;
      jtd_pkg::UpdateDr:
        nextState = tmsS ? jtd_pkg::SelectDr : jtd_pkg::RunTestIdle;
      jtd_pkg::SelectIr:
        nextState = tmsS ? jtd_pkg::TestLogicReset : jtd_pkg::CaptureIr;
      jtd_pkg::CaptureIr:
        nextState = tmsS ? jtd_pkg::Exit1Ir : jtd_pkg::ShiftIr;
      jtd_pkg::ShiftIr:
        nextState = tmsS ? jtd_pkg::Exit1Ir : jtd_pkg::ShiftIr;
      jtd_pkg::Exit1Ir:
        nextState = tmsS ? jtd_pkg::UpdateIr : jtd_pkg::PauseIr;
      jtd_pkg::PauseIr:
        nextState = tmsS ? jtd_pkg::Exit2Ir : jtd_pkg::PauseIr;
      jtd_pkg::Exit2Ir:
        nextState = tmsS ? jtd_pkg::UpdateIr : jtd_pkg::ShiftIr;
      jtd_pkg::UpdateIr:
        nextState = tmsS ? jtd_pkg::SelectDr : jtd_pkg::RunTestIdle;
      default:
        nextState = jtd_pkg::TestLogicReset;
    endcase
  end

  // next-state for all registers
  always_comb begin
    r_next = r_reg;
    r_next.tckSync = {r_reg.tckSync[0], tck};
    r_next.tmsSync = {r_reg.tmsSync[0], tms};
    r_next.tdiSync = {r_reg.tdiSync[0], tdi};
    r_next.trstSync = {r_reg.trstSync[0], trstN};
    r_next.coreSync = {r_reg.coreSync[0], coreTdo};
    // boundary pins are asynchronous too, so they get the same two flops
    r_next.pinSync = {r_reg.pinSync[0], pinSample};
    r_next.tckLast = r_reg.tckSync[1];
    if (trstActive) begin
      // held in reset regardless of tck activity
      r_next.state = jtd_pkg::TestLogicReset;
      r_next.irHold = jtd_pkg::InstrIdcode;
      r_next.oe = 1'b0;
    end else if (tckRise) begin
      r_next.state = nextState;
      case (r_reg.state)
        jtd_pkg::TestLogicReset: begin
          r_next.irHold = jtd_pkg::InstrIdcode;
        end
        jtd_pkg::CaptureIr: begin
          r_next.irShift = jtd_pkg::IrCaptureVal;
        end
        jtd_pkg::ShiftIr: begin
          r_next.irShift = {tdiS, r_reg.irShift[jtd_pkg::IrWidth-1:1]};
        end
        jtd_pkg::UpdateIr: begin
          r_next.irHold = r_reg.irShift;
        end
        jtd_pkg::CaptureDr: begin
          if (useId) begin
            r_next.drShift = jtd_pkg::IdcodeVal;
          end else if (useBs) begin
            r_next.drShift = '0;
            r_next.drShift[BsLen-1:0] = r_reg.pinSync[1];
          end else begin
            r_next.drShift = '0; // bypass captures zero
          end
        end
        jtd_pkg::ShiftDr: begin
          // each chain shifts from its own length toward bit 0
          r_next.drShift = r_reg.drShift >> 1;
          if (useId) begin
            r_next.drShift[jtd_pkg::IdWidth-1] = tdiS;
          end else if (useBs) begin
            r_next.drShift[BsLen-1] = tdiS;
          end else begin
            r_next.drShift[0] = tdiS;
          end
        end
        jtd_pkg::UpdateDr: begin
          // extest and intest leave the held cells alone
          if (useBs) begin
            r_next.bsHold = r_reg.drShift[BsLen-1:0];
          end
        end
        default: begin
          r_next.irShift = r_reg.irShift;
        end
      endcase
    end else if (tckFall) begin
      // tdo moves on the falling edge so the tester samples it stable
      r_next.oe = (r_reg.state == jtd_pkg::ShiftDr) |
                  (r_reg.state == jtd_pkg::ShiftIr);
      if (r_reg.state == jtd_pkg::ShiftIr) begin
        r_next.tdo = r_reg.irShift[0];
      end else if (coreSel) begin
        r_next.tdo = r_reg.coreSync[1];
      end else begin
        r_next.tdo = r_reg.drShift[0];
      end
    end
    // test mode is registered so the output comes straight from a flop
    r_next.mode = (r_next.irHold == jtd_pkg::InstrExtest) |
                  (r_next.irHold == jtd_pkg::InstrIntest);
  end

  // single register bank; reset to constants only
  // tck, tms, tdi and trst sync stages start at the pull-up idle level, so no false tck edge follows reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      r_reg <= '0;
      r_reg.tckSync <= '1;
      r_reg.tmsSync <= '1;
      r_reg.tdiSync <= '1;
      r_reg.trstSync <= '1;
      r_reg.tckLast <= 1'b1;
      r_reg.state <= jtd_pkg::TestLogicReset;
      r_reg.irHold <= jtd_pkg::InstrIdcode;
      r_reg.irShift <= jtd_pkg::IrCaptureVal;
    end else begin
      r_reg <= r_next;
    end
  end

  // outputs come straight from the register bank
  assign tdoOut = r_reg.tdo;
  assign tdoOe = r_reg.oe;
  assign pinDrive = r_reg.bsHold;
  assign testMode = r_reg.mode;

endmodule : jtd_tap

// file: jtd_tap_checker.sv
`timescale 1ns/1ns
module jtd_tap_checker #(
  parameter int BsLen = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // jtag and boundary pins
  input wire logic tck,
  input wire logic trstN,
  input wire logic tdoOut,
  input wire logic tdoOe,
  input wire logic [BsLen-1:0] pinDrive,
  input wire logic testMode
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // outputs follow their own tck edge; trst acts after its two-flop sync
  a_tdo_fall: assert property ($changed(tdoOut) |-> !tck && !$past(tck))
    else $error("tdo moved in tck high");
  a_oe_fall: assert property ($rose(tdoOe) |-> !tck && !$past(tck))
    else $error("oe rose in tck high");
  a_drive_rise: assert property ($changed(pinDrive) |-> tck && $past(tck))
    else $error("pin drive moved in tck low");
  a_mode_rise: assert property ($rose(testMode) |-> tck && $past(tck))
    else $error("test mode rose in tck low");
  a_oe_stands: assert property ($rose(tdoOe) ##1 trstN [*5] |-> tdoOe)
    else $error("oe dropped early");
  a_trst_oe: assert property (!trstN [*5] |-> !tdoOe) else $error("oe under trst");
  a_trst_mode: assert property (!trstN [*5] |-> !testMode) else $error("mode kept");
  a_tck_still: assert property ($stable(tck) [*6] |-> $stable(tdoOut))
    else $error("tdo moved with tck still");
  c_shift: cover property ($rose(tdoOe));
  c_mode: cover property ($rose(testMode));
  c_drive: cover property ($changed(pinDrive));
endmodule : jtd_tap_checker

// file: jtd_tester.sv
`timescale 1ns/1ns
module jtd_tester (
  // time base
  input wire logic clk,
  // jtag pins, idle at their pull-up level
  output logic tck = 1'b1,
  output logic tms = 1'b1,
  output logic tdi = 1'b1,
  input wire logic tdoOut,
  input wire logic tdoOe
);
  // one tck bit from a clk fall; tdo read late in the high phase, clear of its update lag
  task automatic step(input logic m, input logic d, output logic o);
    tck = 1'b0;
    tms = m;
    tdi = d;
    repeat (4) @(negedge clk);
    tck = 1'b1;
    repeat (4) @(negedge clk);
    o = tdoOe ? tdoOut : 1'b1;
  endtask : step
  // idle to idle scan, lsb first; tdi rests high outside the shift
  task automatic scan(input logic ir, input logic [31:0] din, input int n,
    output logic [31:0] dout);
    logic o;
    repeat (ir ? 2 : 1) step(1'b1, 1'b1, o);
    repeat (2) step(1'b0, 1'b1, o);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], o);
      dout[i] = o;
    end
    step(1'b1, 1'b1, o);
    step(1'b0, 1'b1, o);
  endtask : scan
endmodule : jtd_tester

// file: tb_jtd_tap.sv
`timescale 1ns/1ns
module tb_jtd_tap;
  logic clk = 1'b0, arst_n = 1'b0, trstN = 1'b1, coreTdo = 1'b0;
  logic [7:0] pinSample = 8'ha5, pinDrive;
  logic tck, tms, tdi, tdoOut, tdoOe, testMode;
  logic [31:0] d;
  int error_cnt = 0, n_tests = 0;
  always #20 clk = ~clk;
  jtd_tap uut (.clk, .arst_n, .tck, .tms, .tdi, .trstN, .tdoOut, .tdoOe, .coreTdo,
    .pinSample, .pinDrive, .testMode);
  jtd_tester tester (.clk, .tck, .tms, .tdi, .tdoOut, .tdoOe);
  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic stop_test();
    $display("tests %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test
  // each code in turn, then two dr bits through the path it picks
  task automatic t_codes();
    logic [1:0] e;
    for (int c = 0; c < 16; c++) begin
      coreTdo = c[0];
      tester.scan(1'b1, c, 4, d);
      chk("ir capture", d[3:0], jtd_pkg::IrCaptureVal);
      chk("test mode", testMode, c < 2);
      tester.scan(1'b0, 32'h1, 2, d);
      e = c == 2 ? pinSample[1:0] : c == 14 ? jtd_pkg::IdcodeVal[1:0] : 2'b10;
      if (c == 8 || c == 10 || c == 11) e = {2{c[0]}};
      chk("dr path", d[1:0], e);
      // only sample/preload loads the held cells: tdi 1 then 0 behind the capture
      chk("pin drive", pinDrive, c < 2 ? 8'h00 : {2'b01, pinSample[7:2]});
    end
  endtask : t_codes
  // trst pulse, then five tms highs, each from a loaded bypass
  task automatic t_resets();
    for (int k = 0; k < 2; k++) begin
      tester.scan(1'b1, jtd_pkg::InstrBypass, 4, d);
      trstN = k[0];
      repeat (8) @(negedge clk);
      trstN = 1'b1;
      repeat (k * 5) tester.step(1'b1, 1'b1, d[0]);
      tester.step(1'b0, 1'b1, d[0]);
      tester.scan(1'b0, 32'h0, 32, d);
      chk("idcode", d, jtd_pkg::IdcodeVal);
    end
  endtask : t_resets
  initial begin
    repeat (3) @(negedge clk);
    arst_n = 1'b1;
    repeat (4) @(negedge clk);
    tester.step(1'b0, 1'b1, d[0]);
    t_codes();
    t_resets();
    stop_test();
  end
endmodule : tb_jtd_tap
bind jtd_tap jtd_tap_checker #(.BsLen(BsLen)) u_chk (.clk, .arst_n, .tck, .trstN, .tdoOut,
  .tdoOe, .pinDrive, .testMode);
